/* File: rtc_calendar.sv */
// calendar-mode real time counter with axi4-lite registers and events
`timescale 1ns/1ps

module rtc_calendar
  import rtc_cal_pkg::*;
#(
  parameter int PRE_W       = 10,
  parameter int SYNC_CYCLES = 4
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        rtc_source_clock,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output events_s          event_out,
  output logic             irq
);

  localparam logic [3:0] SYNC_LAST = 4'(SYNC_CYCLES - 1);
  // days in a month, leap test on the two low year bits
  function automatic logic [4:0] days_in(input logic [3:0] mon, input logic leap);
    case (mon)
      4'h2:    days_in = leap ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: days_in = 5'h1e;
      default: days_in = 5'h1f;
    endcase
  endfunction : days_in
  // one-second advance; msb of result is the year-63 wrap
  function automatic logic [32:0] cal_next(input calendar_s c, input logic h12);
    calendar_s n;
    logic      cy;
    n  = c;
    cy = 1'b0;
    n.second = c.second + 6'h01;
    if (c.second == 6'h3b)
    begin
      n.second = 6'h00;
      n.minute = c.minute + 6'h01;
      if (c.minute == 6'h3b)
      begin
        n.minute = 6'h00;
        if (h12)
        begin
          n.hour = c.hour + 5'h01;
          if (c.hour[3:0] == 4'hc)
            n.hour = {c.hour[4], 4'h1};
          else if (c.hour[3:0] == 4'hb)
          begin
            n.hour = {~c.hour[4], 4'hc};
            cy     = c.hour[4];
          end
        end
        else
        begin
          n.hour = c.hour + 5'h01;
          if (c.hour == 5'h17)
          begin
            n.hour = 5'h00;
            cy     = 1'b1;
          end
        end
        if (cy)
        begin
          cy    = 1'b0;
          n.day = c.day + 5'h01;
          if (c.day == days_in(c.month, c.year[1:0] == 2'h0))
          begin
            n.day   = 5'h01;
            n.month = c.month + 4'h1;
            if (c.month == 4'hc)
            begin
              n.month = 4'h1;
              n.year  = c.year + 6'h01;
              cy      = (c.year == 6'h3f);
            end
          end
        end
      end
    end
    cal_next = {cy, n};
  endfunction : cal_next

  // registers
  logic [31:0]      ctrl_ff;
  logic [15:0]      event_output_ctrl_ff;
  logic [7:0]       ien_ff;
  logic [7:0]       flag_ff;
  calendar_s        cal_ff;
  logic [31:0]      alarm_ff;
  logic [2:0]       mask_ff;
  logic [PRE_W-1:0] pre_ff;
  logic             src_ff;
  logic             srst_ff;
  sync_e            sync_ff;
  logic [3:0]       scnt_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [1:0]       rresp_ff;
  logic [31:0]      rdata_ff;
  events_s          event_ff;

  // bus decode
  wire wr_ctrl  = s_axi_awaddr == OFS_CTRL;
  wire wr_ev    = s_axi_awaddr == OFS_EVENT_OUTPUT_CTRL;
  wire wr_iclr  = s_axi_awaddr == OFS_IEN_CLR;
  wire wr_iset  = s_axi_awaddr == OFS_IEN_SET;
  wire wr_flag  = s_axi_awaddr == OFS_IRQFLAG;
  wire wr_stat  = s_axi_awaddr == OFS_STATUS;
  wire wr_clock = s_axi_awaddr == OFS_CLOCK;
  wire wr_alarm = s_axi_awaddr == OFS_ALARM;
  wire wr_mask  = s_axi_awaddr == OFS_MASK;
  wire wr_hit   = wr_ctrl | wr_ev | wr_iclr | wr_iset | wr_flag | wr_stat
                | wr_clock | wr_alarm | wr_mask;
  wire wr_sync  = wr_ctrl | wr_clock | wr_alarm | wr_mask;
  wire rd_sync  = s_axi_araddr == OFS_CLOCK;
  wire busy     = sync_ff == SYNC_BUSY;
  // a synced access waits while busy, so nothing is dropped
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff
             & ~(wr_sync & busy);
  wire rd_go = s_axi_arvalid & ~rvalid_ff & ~(rd_sync & busy);
  wire w_ok  = wr_go & wr_hit;
  wire sync_start = (w_ok & wr_sync) | (rd_go & rd_sync);
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  // byte-lane merge of the write data
  wire [31:0] strb_m = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire [31:0] wd      = s_axi_wdata;
  wire [31:0] ctrl_in = (ctrl_ff & ~strb_m) | (wd & strb_m);

  // control fields
  wire       en      = ctrl_ff[CTRL_ENABLE];
  wire [1:0] mode    = ctrl_ff[CTRL_MODE_LO +: 2];
  wire       h12     = ctrl_ff[CTRL_HFMT];
  wire       mclr    = ctrl_ff[CTRL_MCLR];
  wire [3:0] presc   = ctrl_ff[CTRL_PRE_LO +: 4];
  wire       cal_run = en & (mode == MODE_CALENDAR);

  // enable-protected fields keep their value while running
  wire [31:0] prot_m  = 32'h0000_0fcc;
  wire [31:0] ctrl_wr = en ? ((ctrl_in & ~prot_m) | (ctrl_ff & prot_m))
                           : ctrl_in;
  wire [31:0] ctrl_nx = {20'h0, ctrl_wr[11:8], ctrl_wr[7:6], 2'h0,
                         ctrl_wr[3:0]};

  // prescaler and tick; source level is sampled on aclk
  wire              src_edge = rtc_source_clock & ~src_ff;
  wire              pre_step = src_edge & en;
  wire [PRE_W:0]    low_m1   = ({{PRE_W{1'b0}}, 1'b1} << presc) - 1'b1;
  wire [PRE_W-1:0]  low_m    = low_m1[PRE_W-1:0];
  wire              tick     = pre_step & ((pre_ff & low_m) == low_m)
                             & cal_run;

  // alarm compare with field masking
  logic [31:0] am;
  always_comb
  begin
    case (mask_ff)
      3'h1:    am = AM_SS;
      3'h2:    am = AM_MMSS;
      3'h3:    am = AM_HMS;
      3'h4:    am = AM_DD;
      3'h5:    am = AM_MM;
      3'h6:    am = AM_YY;
      default: am = 32'h0;
    endcase
  end
  wire am_on = (mask_ff != 3'h0) & (mask_ff != 3'h7);
  wire match = am_on & (((cal_ff ^ alarm_ff) & am) == 32'h0);

  // next calendar value
  wire [32:0]     inc      = cal_next(cal_ff, h12);
  wire            yr_wrap  = inc[32];
  wire [31:0]     cal_zero = {CAL_RESET[31:17], (h12 ? HOUR_12AM : 5'h00),
                              CAL_RESET[11:0]};
  wire            hit_clr  = tick & match & mclr;
  wire            ev_wrap  = tick & (yr_wrap | (match & mclr));
  wire            ev_alarm = tick & match;

  // periodic taps on prescaler bits 2..9
  logic [7:0] per_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_per
      assign per_hit[gi] = pre_step & (presc != 4'h0)
                         & ~pre_ff[gi+2] & (&pre_ff[gi+1:0]);
    end
  endgenerate

  // flag set/clear: a set in the same cycle wins
  wire [7:0] flag_set = {ev_wrap, busy & (scnt_ff == 4'h0), 5'h0, ev_alarm};
  wire [7:0] flag_clr = (w_ok & wr_flag & s_axi_wstrb[0]) ? wd[7:0] : 8'h0;
  wire [7:0] flag_nx  = ((flag_ff & ~flag_clr) | flag_set) & FLAG_MASK;
  wire [7:0] ien_nx = (w_ok & wr_iset & s_axi_wstrb[0]) ? (ien_ff | wd[7:0])
                    : (w_ok & wr_iclr & s_axi_wstrb[0]) ? (ien_ff & ~wd[7:0])
                    : ien_ff;

  // request straight from flag and enable, no clock needed to assert
  assign irq = |(flag_ff & ien_ff & FLAG_MASK);

  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    case (s_axi_araddr)
      OFS_CTRL:    rd_mux = ctrl_ff;
      OFS_EVENT_OUTPUT_CTRL:  rd_mux = {16'h0, event_output_ctrl_ff};
      OFS_IEN_CLR: rd_mux = {24'h0, ien_ff};
      OFS_IEN_SET: rd_mux = {24'h0, ien_ff};
      OFS_IRQFLAG: rd_mux = {24'h0, flag_ff};
      OFS_STATUS:  rd_mux = {24'h0, busy, 7'h0};
      OFS_CLOCK:   rd_mux = cal_ff;
      OFS_ALARM:   rd_mux = alarm_ff;
      OFS_MASK:    rd_mux = {29'h0, mask_ff};
      default:     rd_mux = 32'h0;
    endcase
  end
  wire rd_hit = (s_axi_araddr <= OFS_MASK) & (s_axi_araddr[1:0] == 2'h0);
  // soft reset request, registered, acts on the edge after the accepting one
  wire swrst_req = w_ok & wr_ctrl & s_axi_wstrb[0] & wd[SOFT_RESET_BIT];
  wire rst_all   = ~aresetn | srst_ff;
  // sync tracker: busy from the accepting edge, ready flag when done
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_ff <= SYNC_IDLE;
      scnt_ff <= 4'h0;
    end
    else
    begin
      case (sync_ff)
        SYNC_IDLE:
        begin
          if (sync_start)
          begin
            sync_ff <= SYNC_BUSY;
            scnt_ff <= SYNC_LAST;
          end
        end
        SYNC_BUSY:
        begin
          if (scnt_ff == 4'h0)
            sync_ff <= SYNC_IDLE;
          else
            scnt_ff <= scnt_ff - 4'h1;
        end
        default: sync_ff <= SYNC_IDLE;
      endcase
    end
  end

  // axi response channels; bus state survives soft reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0;
      srst_ff   <= 1'b0;
      src_ff    <= 1'b0;
    end
    else
    begin
      srst_ff <= swrst_req;
      src_ff  <= rtc_source_clock;
      if (wr_go)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
      if (rd_go)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_ff  <= rd_mux;
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // configuration, flags and enables
  always_ff @(posedge aclk)
  begin
    if (rst_all)
    begin
      ctrl_ff   <= 32'h0;
      event_output_ctrl_ff <= 16'h0;
      ien_ff    <= 8'h0;
      flag_ff   <= 8'h0;
      alarm_ff  <= 32'h0;
      mask_ff   <= MASK_RESET;
    end
    else
    begin
      flag_ff <= flag_nx;
      ien_ff  <= ien_nx;
      if (w_ok & wr_ctrl)
        ctrl_ff <= ctrl_nx;
      if (w_ok & wr_ev & ~en)
        event_output_ctrl_ff <= (event_output_ctrl_ff & ~strb_m[15:0]) | (wd[15:0] & strb_m[15:0]);
      if (w_ok & wr_alarm)
        alarm_ff <= (alarm_ff & ~strb_m) | (wd & strb_m);
      if (w_ok & wr_mask & s_axi_wstrb[0])
        mask_ff <= wd[2:0];
    end
  end

  // calendar value and prescaler; bus write beats the tick
  always_ff @(posedge aclk)
  begin
    if (rst_all)
    begin
      cal_ff <= CAL_RESET;
      pre_ff <= '0;
    end
    else
    begin
      if (pre_step)
        pre_ff <= pre_ff + 1'b1;
      if (w_ok & wr_clock)
        cal_ff <= (cal_ff & ~strb_m) | (wd & strb_m);
      else if (hit_clr | (tick & yr_wrap))
        cal_ff <= cal_zero;
      else if (tick)
        cal_ff <= inc[31:0];
    end
  end

  // output events, one-cycle pulses each with own enable
  always_ff @(posedge aclk)
  begin
    if (rst_all)
      event_ff <= '0;
    else
    begin
      event_ff.wrap   <= ev_wrap & event_output_ctrl_ff[EV_WRAP];
      event_ff.alarm  <= ev_alarm & event_output_ctrl_ff[EV_ALARM];
      event_ff.period <= per_hit & event_output_ctrl_ff[7:0];
    end
  end
  assign event_out = event_ff;
endmodule : rtc_calendar

/* File: rtc_cal_pkg.sv */
// package: register map, field positions and types for the calendar counter
package rtc_cal_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_EVENT_OUTPUT_CTRL   = 8'h04;
  localparam logic [7:0] OFS_IEN_CLR  = 8'h08;
  localparam logic [7:0] OFS_IEN_SET  = 8'h0c;
  localparam logic [7:0] OFS_IRQFLAG  = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_CLOCK    = 8'h18;
  localparam logic [7:0] OFS_ALARM    = 8'h1c;
  localparam logic [7:0] OFS_MASK     = 8'h20;

  // control register bit positions
  localparam int SOFT_RESET_BIT   = 0;
  localparam int CTRL_ENABLE  = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_HFMT    = 6;
  localparam int CTRL_MCLR    = 7;
  localparam int CTRL_PRE_LO  = 8;

  // event control bit positions (period enables sit in 7:0)
  localparam int EV_ALARM = 8;
  localparam int EV_WRAP  = 15;

  // interrupt flag / enable and status bit positions
  localparam int FLG_ALARM = 0;
  localparam int FLG_SYNC  = 6;
  localparam int FLG_WRAP  = 7;
  localparam int STS_BUSY  = 7;

  localparam logic [1:0] MODE_CALENDAR = 2'h2;
  localparam logic [7:0] FLAG_MASK     = 8'hc1;

  // reset and wrap values
  localparam logic [31:0] CAL_RESET  = 32'h0042_0000;
  localparam logic [4:0]  HOUR_12AM  = 5'h0c;
  localparam logic [2:0]  MASK_RESET = 3'h0;

  // alarm compare masks by selection value
  localparam logic [31:0] AM_SS   = 32'h0000_003f;
  localparam logic [31:0] AM_MMSS = 32'h0000_0fff;
  localparam logic [31:0] AM_HMS  = 32'h0001_ffff;
  localparam logic [31:0] AM_DD   = 32'h003f_ffff;
  localparam logic [31:0] AM_MM   = 32'h03ff_ffff;
  localparam logic [31:0] AM_YY   = 32'hffff_ffff;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // packed time/date value
  typedef struct packed {
    logic [5:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } calendar_s;

  // one-cycle output event pulses
  typedef struct packed {
    logic       wrap;
    logic       alarm;
    logic [7:0] period;
  } events_s;

  typedef enum logic {
    SYNC_IDLE = 1'b0,
    SYNC_BUSY = 1'b1
  } sync_e;

endpackage : rtc_cal_pkg

/* File: rtc_calendar_sva.sv */
// checker: bus answer, stall and event pulse timing of the calendar counter
`timescale 1ns/1ps
module rtc_calendar_sva
  import rtc_cal_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire events_s     event_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // synced clock read taken; busy must refuse the next one for a while
  wire clk_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_CLOCK;

  sequence s_clk_rd;
    clk_rd;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  property p_stall;
    s_clk_rd |=> !clk_rd [*4];
  endproperty
  property p_wr_ans;
    s_wr_take |=> s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_alarm_pulse;
    event_out.alarm |=> !event_out.alarm;
  endproperty
  property p_wrap_pulse;
    event_out.wrap |=> !event_out.wrap [*2];
  endproperty
  // a source edge takes at least two bus cycles, so eight edges span sixteen
  property p_per0;
    event_out.period[0] |=> !event_out.period[0] [*8];
  endproperty
  property p_per_alt;
    event_out.period[1] |-> !event_out.period[0];
  endproperty

  a_stall: assert property (p_stall) else $error("clock read taken while busy");
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_alarm_pulse: assert property (p_alarm_pulse) else $error("alarm event too long");
  a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap event too long");
  a_per0: assert property (p_per0) else $error("period 0 event too soon");
  a_per_alt: assert property (p_per_alt) else $error("period 0 and 1 together");
endmodule : rtc_calendar_sva

bind rtc_calendar rtc_calendar_sva i_rtc_calendar_sva (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .event_out     (event_out)
);

/* File: test_rtc_calendar.sv */
// self-checking bench for the calendar counter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_rtc_calendar
  import rtc_cal_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, rtc_source_clock = 1'b0, irq;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, r, t;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, m;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, wrs;
  events_s     event_out;
  int          bad_count = 0, n_tests = 0, seed = 32'hbf24, y;
  int          ev_cnt [10] = '{default: 0};
  int          snap [10];

  rtc_calendar i_rtc_calendar (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .rtc_source_clock (rtc_source_clock),
    .s_axi_awaddr     (s_axi_awaddr),
    .s_axi_awvalid    (s_axi_awvalid),
    .s_axi_awready    (s_axi_awready),
    .s_axi_wdata      (s_axi_wdata),
    .s_axi_wstrb      (s_axi_wstrb),
    .s_axi_wvalid     (s_axi_wvalid),
    .s_axi_wready     (s_axi_wready),
    .s_axi_bresp      (s_axi_bresp),
    .s_axi_bvalid     (s_axi_bvalid),
    .s_axi_bready     (s_axi_bready),
    .s_axi_araddr     (s_axi_araddr),
    .s_axi_arvalid    (s_axi_arvalid),
    .s_axi_arready    (s_axi_arready),
    .s_axi_rdata      (s_axi_rdata),
    .s_axi_rresp      (s_axi_rresp),
    .s_axi_rvalid     (s_axi_rvalid),
    .s_axi_rready     (s_axi_rready),
    .event_out        (event_out),
    .irq              (irq)
  );

  initial forever #20 aclk = ~aclk;

  // tally event pulses so scenarios can compare before and after
  always @(posedge aclk)
    for (int i = 0; i < 10; i++) ev_cnt[i] += event_out[i];

  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // response ready comes a cycle late so the hold of an answer is exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    wrs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
    d = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // source clock stands still between bursts; each edge is one tick at prescaler 0
  task automatic edges(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge aclk);
      rtc_source_clock <= 1'b1;
      repeat (3) @(posedge aclk);
      rtc_source_clock <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask : edges

  function automatic logic [31:0] cal(input int yy, mo, d, h, mi, s);
    return {yy[5:0], mo[3:0], d[4:0], h[4:0], mi[5:0], s[5:0]};
  endfunction : cal

  task automatic step(input logic [31:0] s, input logic [31:0] e);
    wr(OFS_CLOCK, s);
    edges(1);
    rd(OFS_CLOCK, v, rs);
    `CHK("clock", e, v)
  endtask : step

  initial
  begin
    #1ms;
    bad_count++;
    give_verdict();
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CLOCK, v, rs);
    `CHK("clock reset", CAL_RESET, v)
    rd(8'h24, v, rs);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {rs, v})
    wr(8'h24, 32'hffff_ffff);
    `CHK("write unmapped", RESP_SLVERR, wrs)
    // synchronised write: busy at once, done flag later, write-one clears
    r = $random(seed);
    wr(OFS_ALARM, r);
    rd(OFS_STATUS, v, rs);
    `CHK("busy", 1'b1, v[STS_BUSY])
    `CHK("write resp", RESP_OKAY, wrs)
    rd(OFS_ALARM, v, rs);
    `CHK("alarm", {RESP_OKAY, r}, {rs, v})
    // only the two low byte lanes of a partial write may land
    s_axi_wstrb <= 4'h3;
    wr(OFS_ALARM, ~r);
    s_axi_wstrb <= 4'hf;
    rd(OFS_ALARM, v, rs);
    `CHK("alarm lanes", {r[31:16], ~r[15:0]}, v)
    wr(OFS_IRQFLAG, 32'h0);
    rd(OFS_IRQFLAG, v, rs);
    `CHK("sync done", 1'b1, v[FLG_SYNC])
    wr(OFS_IRQFLAG, 32'h40);
    rd(OFS_IRQFLAG, v, rs);
    `CHK("sync cleared", 1'b0, v[FLG_SYNC])
    // periodic events over 32 source edges, prescaler 1
    wr(OFS_EVENT_OUTPUT_CTRL, 32'h81ff);
    wr(OFS_CTRL, 32'h10a);
    snap = ev_cnt;
    edges(32);
    wr(OFS_CTRL, 32'h0);
    for (int n = 0; n < 8; n++)
      `CHK("period", (32 + (4 << n)) / (8 << n), ev_cnt[n] - snap[n])
    // calendar steps, random and corner dates
    wr(OFS_CTRL, 32'ha); // prescaler zero: each source edge is one second
    snap = ev_cnt;
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      t = cal(r[31:26], r[25:22] % 12 + 1, r[21:17] % 28 + 1, r[16:12] % 24, r[11:6] % 60,
              r[5:0] % 59);
      step(t, t + 32'h1);
    end
    y = $random(seed) & 32'h3c;
    step(cal(y, 2, 28, 23, 59, 59), cal(y, 2, 29, 0, 0, 0));
    step(cal(y + 1, 2, 28, 23, 59, 59), cal(y + 1, 3, 1, 0, 0, 0));
    step(cal(y, 2, 29, 23, 59, 59), cal(y, 3, 1, 0, 0, 0));
    step(cal(y, 4, 30, 23, 59, 59), cal(y, 5, 1, 0, 0, 0));
    wr(OFS_IRQFLAG, 32'hc1);
    step(cal(63, 12, 31, 23, 59, 59), cal(0, 1, 1, 0, 0, 0));
    rd(OFS_IRQFLAG, v, rs);
    `CHK("wrap flag", 1'b1, v[FLG_WRAP])
    `CHK("wrap event", 1, ev_cnt[9] - snap[9])
    `CHK("no period", snap[0], ev_cnt[0])
    // hour format is locked while running, then 12-hour steps
    wr(OFS_CTRL, 32'h4a);
    rd(OFS_CTRL, v, rs);
    `CHK("format locked", 32'ha, v)
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h4a);
    step(cal(1, 1, 1, 5'h0b, 59, 59), cal(1, 1, 1, 5'h1c, 0, 0));
    step(cal(1, 1, 1, 5'h1b, 59, 59), cal(1, 1, 2, 5'h0c, 0, 0));
    // another mode leaves the clock alone; then every mask selection
    // against an alarm that differs only in the year
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h2);
    step(32'h0123_4567, 32'h0123_4567);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'ha);
    wr(OFS_IEN_SET, 32'h1);
    t = cal(5, 6, 7, 8, 9, 10);
    wr(OFS_ALARM, t ^ 32'h8000_0000);
    for (int s = 0; s < 8; s++)
    begin
      m = s > 0 && s < 6;
      wr(OFS_IRQFLAG, 32'hc1);
      wr(OFS_MASK, s);
      snap = ev_cnt;
      step(t, t + 32'h1);
      rd(OFS_IRQFLAG, v, rs);
      `CHK("alarm flag", m, v[FLG_ALARM])
      @(negedge aclk);
      `CHK("irq", m, irq)
      `CHK("alarm event", m, ev_cnt[8] - snap[8])
    end
    wr(OFS_MASK, 32'h1);
    step(t, t + 32'h1);
    @(negedge aclk);
    `CHK("irq held", 1'b1, irq)
    wr(OFS_IEN_CLR, 32'h1);
    @(negedge aclk);
    `CHK("irq off", 1'b0, irq)
    // clear on match reloads the start date and raises both flags
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h8a);
    wr(OFS_MASK, 32'h6);
    wr(OFS_ALARM, t);
    wr(OFS_IRQFLAG, 32'hc1);
    step(t, cal(0, 1, 1, 0, 0, 0));
    rd(OFS_IRQFLAG, v, rs);
    `CHK("both flags", 8'h81, v[7:0] & 8'h81)
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_CLOCK, v, rs);
    `CHK("soft reset", CAL_RESET, v)
    give_verdict();
  end
endmodule : test_rtc_calendar
